// ===== rtl/ddrtb_top.v
// DQ bus turnaround controller of a common-I/O burst-of-2 DDR SRAM.
//
// Notes on behaviour
// RQ1 - No write-side command right after a Read.
// RQ2 - Termination off 2.5 cycles after last write.
// RQ3 - Drive low one cycle before first read.
// RQ4 - Drive low one cycle after last read.
// RQ5 - Termination on one cycle before first write.
// RQ6 - Controller inserts idles at turnarounds: 0/0, 2/3.
// RQ7 - Typical idle gaps recommended for the controller.
// RQ8 - Controller terminates after device low, before data.
// RQ9 - Controller unterminates after trailing low, before ours.
// RQ10 - Controller sends write data after our termination.
// RQ11 - Controller stops write data before termination off.
// RQ12 - Controller drives low when idle and unterminated.
// RQ13 - Unterminated and not reading: drive bus low.
// RQ14 - Address, strobe, select sampled on master rise.
// RQ15 - Clock pair 0 captures the low lanes.
// RQ16 - Clock pair 1 captures the high lanes.
// RQ17 - Select high: termination off, bus low.
// RQ18 - Select low: drivers off, termination on.
// RQ19 - Read must be followed by select high.
// RQ20 - Controller tracks history to check turnarounds.
`timescale 1ns/1ps
`include "ddrtb_consts.vh"

module ddrtb_top #(
   parameter DQ_W       = `DDRTB_DQ_W,
   parameter ADDR_W     = `DDRTB_ADDR_W,
   parameter FIFO_DEPTH = `DDRTB_FIFO_DEPTH,
   parameter FIFO_AW    = `DDRTB_FIFO_AW
) (
   // Clock and reset.
   input  wire              CLK,
   input  wire              RST,
   // Master clock and command pins.
   input  wire              CK,
   input  wire              LOAD_STROBE_N,
   input  wire              RW_SELECT,
   input  wire [ADDR_W-1:0] ADDR_INPUTS,
   // Write data clock pairs.
   input  wire [1:0]        WRITE_DATA_CLOCK,
   input  wire [1:0]        WRITE_DATA_CLOCK_N,
   // Data bus pin, split into input, output and enable.
   input  wire [DQ_W-1:0]   DQ_I,
   output wire [DQ_W-1:0]   DQ_O,
   output wire              DQ_OE_N,
   output wire              ODT_EN,
   // Read request towards the array and its data.
   output wire              RD_REQ,
   output wire [ADDR_W-1:0] RD_ADDR,
   input  wire [DQ_W-1:0]   RD_Q1,
   input  wire [DQ_W-1:0]   RD_Q2,
   // Write words towards the array.
   output wire              WR_VALID,
   input  wire              WR_READY,
   output wire [ADDR_W-1:0] WR_ADDR,
   output wire [DQ_W-1:0]   WR_D1,
   output wire [DQ_W-1:0]   WR_D2,
   // Status.
   output wire              OVERFLOW,
   output wire [1:0]        BUS_STATE
);

   localparam HALF = DQ_W / 2;
   localparam FW   = ADDR_W + 2 * DQ_W;
   localparam SW   = 7 + ADDR_W + DQ_W;

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************

   wire [SW-1:0]     pins;
   reg  [SW-1:0]     sync_a;
   reg  [SW-1:0]     sync_b;
   wire [DQ_W-1:0]   dq_s;
   wire [ADDR_W-1:0] addr_s;
   wire [1:0]        kdn_s;
   wire [1:0]        kd_s;
   wire              ls_s;
   wire              rw_s;
   wire              ck_s;

   assign pins = {CK, RW_SELECT, LOAD_STROBE_N, WRITE_DATA_CLOCK,
                  WRITE_DATA_CLOCK_N, ADDR_INPUTS, DQ_I};

   // All pins pass the same two stages, so data and clocks stay aligned.
   always @(posedge CLK)
   begin
      if (RST)
      begin
         sync_a <= {SW{1'b0}};
         sync_b <= {SW{1'b0}};
      end
      else
      begin
         sync_a <= pins;
         sync_b <= sync_a;
      end
   end

   // Fields of the second stage.
   assign dq_s   = sync_b[DQ_W-1:0];
   assign addr_s = sync_b[DQ_W +: ADDR_W];
   assign kdn_s  = sync_b[DQ_W+ADDR_W +: 2];
   assign kd_s   = sync_b[DQ_W+ADDR_W+2 +: 2];
   assign ls_s   = sync_b[SW-3];
   assign rw_s   = sync_b[SW-2];
   assign ck_s   = sync_b[SW-1];

   // ****************************************************************
   // Clock edge detection
   // ****************************************************************

   reg        ck_d;
   reg  [1:0] kd_d;
   reg  [1:0] kdn_d;
   wire       ck_rise;
   wire       ck_fall;
   wire [1:0] kd_rise;
   wire [1:0] kdn_rise;

   // Previous levels of the synchronised clocks.
   always @(posedge CLK)
   begin
      if (RST)
      begin
         ck_d  <= 1'b0;
         kd_d  <= 2'h0;
         kdn_d <= 2'h0;
      end
      else
      begin
         ck_d  <= ck_s;
         kd_d  <= kd_s;
         kdn_d <= kdn_s;
      end
   end

   // Edges are one-cycle strobes in the CLK domain.
   assign ck_rise  = ck_s & ~ck_d;
   assign ck_fall  = ~ck_s & ck_d;
   assign kd_rise  = kd_s & ~kd_d;
   assign kdn_rise = kdn_s & ~kdn_d;

   // ****************************************************************
   // Command sampling and history
   // ****************************************************************

   wire       cmd_read;
   wire       cmd_write;
   reg  [2:0] rd_hist;
   reg  [1:0] rw_hist;
   reg  [1:0] next_state;

   // Commands are decoded only at a master clock rise.
   assign cmd_read  = ck_rise & ~ls_s & rw_s;      // RQ14
   assign cmd_write = ck_rise & ~ls_s & ~rw_s;     // RQ14

   // The slot now starting belongs to a Read three commands back, else
   // the select of two commands back decides low drive or termination.
   // A write-side command right after a Read is not guarded; the slot
   // then shows read data, which the controller must not rely on.
   always @*
   begin
      if (rd_hist[`DDRTB_RD_TAP])
         next_state = `DDRTB_ST_READ;
      else if (rw_hist[`DDRTB_RW_TAP])
         next_state = `DDRTB_ST_LOW;                // RQ17 RQ4
      else
         next_state = `DDRTB_ST_TERM;               // RQ18
   end

   // History shifts once per master cycle.
   always @(posedge CLK)
   begin
      if (RST)
      begin
         rd_hist <= `DDRTB_RD_HIST_RST;
         rw_hist <= `DDRTB_RW_HIST_RST;
      end
      else if (ck_rise)
      begin
         rd_hist <= {rd_hist[1:0], cmd_read};
         rw_hist <= {rw_hist[0], rw_s};             // RQ14
      end
   end

   // ****************************************************************
   // Bus drive, termination and read data
   // ****************************************************************

   reg [1:0]        bus_state;
   reg [DQ_W-1:0]   dq_o;
   reg [DQ_W-1:0]   q2_hold;
   reg              dq_oe_n;
   reg              odt_en;
   reg              rd_req;
   reg [ADDR_W-1:0] rd_addr;

   // Low drive, termination and read slots all start at a master rise;
   // the second read piece goes out at the following master fall.
   always @(posedge CLK)
   begin
      if (RST)
      begin
         bus_state <= `DDRTB_ST_LOW;
         dq_o      <= {DQ_W{1'b0}};
         q2_hold   <= {DQ_W{1'b0}};
         dq_oe_n   <= 1'b0;
         odt_en    <= 1'b0;
      end
      else if (ck_rise)
      begin
         bus_state <= next_state;
         case (next_state)
            `DDRTB_ST_READ:
            begin
               dq_o    <= RD_Q1;
               q2_hold <= RD_Q2;
               dq_oe_n <= 1'b0;
               odt_en  <= 1'b0;
            end
            `DDRTB_ST_TERM:
            begin
               dq_o    <= {DQ_W{1'b0}};
               dq_oe_n <= 1'b1;                     // RQ18
               odt_en  <= 1'b1;                     // RQ5
            end
            default:
            begin
               dq_o    <= {DQ_W{1'b0}};             // RQ13
               dq_oe_n <= 1'b0;                     // RQ3
               odt_en  <= 1'b0;                     // RQ2
            end
         endcase
      end
      else if (ck_fall && bus_state == `DDRTB_ST_READ)
         dq_o <= q2_hold;
   end

   // A Read asks the array for its word three master cycles ahead.
   always @(posedge CLK)
   begin
      if (RST)
      begin
         rd_req  <= 1'b0;
         rd_addr <= {ADDR_W{1'b0}};
      end
      else
      begin
         rd_req <= cmd_read;
         if (cmd_read)
            rd_addr <= addr_s;                      // RQ14
      end
   end

   // The trailing low drive after a read is the low branch of the history.

   // ****************************************************************
   // Write data capture
   // ****************************************************************

   wire [DQ_W-1:0] wd1;
   wire [DQ_W-1:0] wd2;

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1)
      begin : pair
         reg [HALF-1:0] d1;
         reg [HALF-1:0] d2;

         // Each clock pair owns one half of the lanes.
         always @(posedge CLK)
         begin
            if (RST)
            begin
               d1 <= {HALF{1'b0}};
               d2 <= {HALF{1'b0}};
            end
            else
            begin
               if (kd_rise[g])
                  d1 <= dq_s[g*HALF +: HALF];       // RQ15 RQ16
               if (kdn_rise[g])
                  d2 <= dq_s[g*HALF +: HALF];       // RQ15 RQ16
            end
         end

         assign wd1[g*HALF +: HALF] = d1;
         assign wd2[g*HALF +: HALF] = d2;
      end
   endgenerate

   // ****************************************************************
   // Write word buffering
   // ****************************************************************

   reg              wr_pend;
   reg [ADDR_W-1:0] wr_addr;
   reg              overflow;
   reg              wr_valid;
   reg [FW-1:0]     wr_word;
   wire             push_valid;
   wire             push_ready;
   wire             f_valid;
   wire [FW-1:0]    f_data;
   wire             take;

   // A Write's pieces arrive within its own cycle, so the word is
   // complete at the next master rise.
   always @(posedge CLK)
   begin
      if (RST)
      begin
         wr_pend <= 1'b0;
         wr_addr <= {ADDR_W{1'b0}};
      end
      else if (ck_rise)
      begin
         wr_pend <= cmd_write;
         if (cmd_write)
            wr_addr <= addr_s;
      end
   end

   assign push_valid = ck_rise & wr_pend;
   assign take       = ~wr_valid | WR_READY;

   // The pins cannot be stalled, so a refused word is dropped and the
   // loss is kept visible until reset.
   always @(posedge CLK)
   begin
      if (RST)
         overflow <= 1'b0;
      else if (push_valid & ~push_ready)
         overflow <= 1'b1;
   end

   ddrtb_fifo #(
      .WIDTH (FW),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_fifo (
      .clk       (CLK),
      .rst       (RST),
      .in_valid  (push_valid),
      .in_ready  (push_ready),
      .in_data   ({wr_addr, wd2, wd1}),
      .out_valid (f_valid),
      .out_ready (take),
      .out_data  (f_data)
   );

   // Output register keeps the array-side outputs on flip-flops.
   always @(posedge CLK)
   begin
      if (RST)
      begin
         wr_valid <= 1'b0;
         wr_word  <= {FW{1'b0}};
      end
      else if (take)
      begin
         wr_valid <= f_valid;
         if (f_valid)
            wr_word <= f_data;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************

   assign DQ_O      = dq_o;
   assign DQ_OE_N   = dq_oe_n;
   assign ODT_EN    = odt_en;
   assign RD_REQ    = rd_req;
   assign RD_ADDR   = rd_addr;
   assign WR_VALID  = wr_valid;
   assign WR_ADDR   = wr_word[2*DQ_W +: ADDR_W];
   assign WR_D2     = wr_word[DQ_W +: DQ_W];
   assign WR_D1     = wr_word[DQ_W-1:0];
   assign OVERFLOW  = overflow;
   assign BUS_STATE = bus_state;

endmodule // ddrtb_top

// ===== rtl/ddrtb_consts.vh
// Constants shared by the DQ bus turnaround controller and its write FIFO.
`ifndef DDRTB_CONSTS_VH
`define DDRTB_CONSTS_VH

// ****************************************************************
// Widths and depths
// ****************************************************************
`define DDRTB_DQ_W          36
`define DDRTB_ADDR_W        21
`define DDRTB_FIFO_DEPTH    8
`define DDRTB_FIFO_AW       3

// ****************************************************************
// Bus slot states, also shown on BUS_STATE
// ****************************************************************
`define DDRTB_ST_LOW        2'h0
`define DDRTB_ST_TERM       2'h1
`define DDRTB_ST_READ       2'h2

// ****************************************************************
// Command history taps and reset values
// ****************************************************************
`define DDRTB_RD_TAP        2
`define DDRTB_RW_TAP        1
`define DDRTB_RD_HIST_RST   3'h0
`define DDRTB_RW_HIST_RST   2'h3

`endif

// ===== rtl/ddrtb_fifo.v
// Small flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps

module ddrtb_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   // Clock and reset.
   input  wire             clk,
   input  wire             rst,
   // Filling side.
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   // Draining side.
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);

   // Depth is cut to the pointer widths on purpose; AW must fit DEPTH.
   localparam [31:0]   DEPTH_V = DEPTH;
   localparam [AW:0]   FULL    = DEPTH_V[AW:0];
   localparam [AW-1:0] LAST    = DEPTH_V[AW-1:0] - 1'b1;

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr;
   reg [AW-1:0]    rd_ptr;
   reg [AW:0]      count;

   wire            push;
   wire            pop;

   // Full and empty come from the count, so both are exact.
   assign in_ready  = (count != FULL);
   assign out_valid = (count != {(AW+1){1'b0}});
   assign out_data  = mem[rd_ptr];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Storage is written only on an accepted push.
   always @(posedge clk)
   begin
      if (push)
         mem[wr_ptr] <= in_data;
   end

   // Pointers wrap at the last entry, so any depth that AW can address works.
   always @(posedge clk)
   begin
      if (rst)
      begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count  <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
            wr_ptr <= (wr_ptr == LAST) ? {AW{1'b0}} : wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= (rd_ptr == LAST) ? {AW{1'b0}} : rd_ptr + 1'b1;
         if (push & ~pop)
            count <= count + 1'b1;
         else if (pop & ~push)
            count <= count - 1'b1;
      end
   end

endmodule // ddrtb_fifo

// ===== verif/ddrtb_properties.sv
// Concurrent checks on the ports of the DQ bus turnaround controller.
`timescale 1ns/1ps
`include "ddrtb_consts.vh"

module ddrtb_properties #(
   parameter DQ_W   = 36,
   parameter ADDR_W = 21
) (
   // Clock and reset.
   input wire              CLK,
   input wire              RST,
   // Bus side outputs.
   input wire [DQ_W-1:0]   DQ_O,
   input wire              DQ_OE_N,
   input wire              ODT_EN,
   input wire [1:0]        BUS_STATE,
   // Array side ports.
   input wire              RD_REQ,
   input wire              WR_VALID,
   input wire              WR_READY,
   input wire [ADDR_W-1:0] WR_ADDR,
   input wire              OVERFLOW
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   // ****************************************************************
   // Bus slot relations
   // ****************************************************************
   // Termination and drive must never overlap, or the bus floats to mid level.
   AST_TERM_XOR_DRIVE: assert property (ODT_EN == DQ_OE_N)
      else $error("termination and drive enable disagree");
   AST_LOW_DRIVES_ZERO: assert property (BUS_STATE == `DDRTB_ST_LOW
      |-> !DQ_OE_N && DQ_O == '0)
      else $error("low slot does not drive zero");
   AST_TERM_RELEASES: assert property (BUS_STATE == `DDRTB_ST_TERM |-> DQ_OE_N && ODT_EN)
      else $error("terminated slot still drives");
   AST_READ_DRIVES: assert property (BUS_STATE == `DDRTB_ST_READ |-> !DQ_OE_N && !ODT_EN)
      else $error("read slot not driven");
   AST_LOW_BEFORE_READ: assert property ($changed(BUS_STATE)
      && BUS_STATE == `DDRTB_ST_READ |-> $past(BUS_STATE) == `DDRTB_ST_LOW)
      else $error("read data not preceded by low drive");
   AST_LOW_AFTER_READ: assert property ($changed(BUS_STATE)
      && $past(BUS_STATE) == `DDRTB_ST_READ |-> BUS_STATE == `DDRTB_ST_LOW)
      else $error("read data not followed by low drive");
   AST_SLOT_HOLDS: assert property ($changed(BUS_STATE) |=> $stable(BUS_STATE) [*6])
      else $error("bus slot shorter than a master clock period");
   AST_READ_LATENCY: assert property (RD_REQ |-> ##[23:25] BUS_STATE == `DDRTB_ST_READ)
      else $error("read data slot missing after read request");
   // Array side handshakes.
   AST_REQ_PULSE: assert property (RD_REQ |=> !RD_REQ)
      else $error("read request longer than one cycle");
   AST_OVERFLOW_STICKY: assert property (OVERFLOW |=> OVERFLOW)
      else $error("overflow flag cleared without reset");
   AST_WORD_HOLDS: assert property (WR_VALID && !WR_READY |=> WR_VALID && $stable(WR_ADDR))
      else $error("write word changed before taken");
endmodule // ddrtb_properties

bind ddrtb_top ddrtb_properties #(.DQ_W(DQ_W), .ADDR_W(ADDR_W)) u_props (
   .CLK(CLK), .RST(RST), .DQ_O(DQ_O), .DQ_OE_N(DQ_OE_N), .ODT_EN(ODT_EN),
   .BUS_STATE(BUS_STATE), .RD_REQ(RD_REQ), .WR_VALID(WR_VALID),
   .WR_READY(WR_READY), .WR_ADDR(WR_ADDR), .OVERFLOW(OVERFLOW)
);

// ===== verif/ddrtb_ctrl_model.sv
// Behavioural memory controller driving master clock, commands and write data.
`timescale 1ns/1ps

module ddrtb_ctrl_model #(
   parameter DQ_W   = 36,
   parameter ADDR_W = 21
) (
   // Bench clock.
   input  wire              clk,
   // Pins towards the device.
   output reg               ck        = 1'b0,
   output reg               ls_n      = 1'b1,
   output reg               rw        = 1'b1,
   output reg  [ADDR_W-1:0] addr      = '0,
   output reg  [1:0]        wdclk     = 2'h0,
   output reg  [1:0]        wdclk_n   = 2'h3,
   output reg  [DQ_W-1:0]   dq_drive  = '0,
   // Command of the current slot and position in it.
   output reg  [1:0]        slot_kind = 2'h0,
   output reg  [2:0]        phase     = 3'h0
);
   // ****************************************************************
   // Command queue
   // ****************************************************************
   reg [1:0]        q_kind [$];
   reg [ADDR_W-1:0] q_addr [$];
   reg [DQ_W-1:0]   q_d1   [$];
   reg [DQ_W-1:0]   q_d2   [$];
   reg [1:0]        cmd_kind = 2'h0;
   reg [DQ_W-1:0]   d1       = '0;
   reg [DQ_W-1:0]   d2       = '0;
   reg [1:0]        k;
   // Termination covers only the read data slots, so it goes on after the
   // low drive before them and off before the trailing low drive ends.
   reg [2:0]        rd_back  = 3'h0;
   reg              term_on  = 1'b0;

   // Kinds: 0 read-side idle, 1 write-side idle, 2 read, 3 write.
   task push(input [1:0] kind, input [ADDR_W-1:0] a, input [DQ_W-1:0] x1, input [DQ_W-1:0] x2);
      q_kind.push_back(kind);
      q_addr.push_back(a);
      q_d1.push_back(x1);
      q_d2.push_back(x2);
   endtask

   // Pins move on the falling bench edge, well away from the device's sampling edge.
   always @(negedge clk)
   begin
      phase   <= phase + 3'h1;
      ck      <= (phase == 3'h7) || (phase < 3'h3);
      wdclk   <= {2{(phase > 3'h0) && (phase < 3'h5)}};
      wdclk_n <= {2{!((phase > 3'h0) && (phase < 3'h5))}};
      if (phase == 3'h7)
      begin
         slot_kind <= cmd_kind;
         rd_back   <= {rd_back[1:0], cmd_kind == 2'h2};
         term_on   <= rd_back[2];
         dq_drive  <= (cmd_kind == 2'h3) ? d1 : '0;
      end
      if (phase == 3'h3)
         dq_drive <= (slot_kind == 2'h3) ? d2 : '0;
      if (phase == 3'h5)
      begin
         k = 2'h0;
         if (q_kind.size() > 0)
         begin
            k = q_kind.pop_front();
            addr <= q_addr.pop_front();
            d1 = q_d1.pop_front();
            d2 = q_d2.pop_front();
         end
         // A write-side command straight after a read is never sent.
         if ((cmd_kind == 2'h2) && k[0])
            k = 2'h0;
         cmd_kind <= k;
         ls_n     <= !k[1];
         rw       <= !k[0];
      end
   end
endmodule // ddrtb_ctrl_model

// ===== verif/test_ddrtb_top.sv
// Self-checking bench of the turnaround controller with a controller model.
`timescale 1ns/1ps
`include "ddrtb_consts.vh"
`define CHECK(got, exp, msg) \
   begin \
      num_checks = num_checks + 1; \
      if ((got) !== (exp)) \
      begin \
         n_mismatch = n_mismatch + 1; \
         $display("mismatch at %0t: %s", $time, msg); \
      end \
   end

module test_ddrtb_top;
   localparam DW = `DDRTB_DQ_W;
   localparam AW = `DDRTB_ADDR_W;
   // Design ports.
   reg            CLK      = 1'b0;
   reg            RST      = 1'b1;
   reg            WR_READY = 1'b0;
   reg  [DW-1:0]  RD_Q1    = 36'h9A5C3E71B;
   reg  [DW-1:0]  RD_Q2    = 36'h5B7E0D2C4;
   wire           CK, LOAD_STROBE_N, RW_SELECT, DQ_OE_N, ODT_EN, RD_REQ, WR_VALID, OVERFLOW;
   wire [AW-1:0]  ADDR_INPUTS, RD_ADDR, WR_ADDR;
   wire [DW-1:0]  DQ_I, DQ_O, WR_D1, WR_D2, dq_drive;
   wire [1:0]     WRITE_DATA_CLOCK, WRITE_DATA_CLOCK_N, BUS_STATE, slot_kind;
   wire [2:0]     phase;
   // Bench state.
   int            n_mismatch = 0;
   int            num_checks = 0;
   int            n_rd       = 0;
   int            seq_n      = 0;
   reg  [AW-1:0]  last_rd;
   reg  [1:0]     h0 = 2'h0, h1 = 2'h0, h2 = 2'h0, exp_st, prev_st = 2'h0;
   reg            mon_on     = 1'b0;
   reg  [AW-1:0]  e_addr [$];
   reg  [DW-1:0]  e_d1   [$];
   reg  [DW-1:0]  e_d2   [$];

   // The controller drives low or write data whenever the device lets go of the bus.
   assign DQ_I = DQ_OE_N ? dq_drive : DQ_O;

   // Bench clock, 8 ns period.
   always #4 CLK = ~CLK;

   ddrtb_ctrl_model #(.DQ_W(DW), .ADDR_W(AW)) u_ctrl (
      .clk(CLK), .ck(CK), .ls_n(LOAD_STROBE_N), .rw(RW_SELECT), .addr(ADDR_INPUTS),
      .wdclk(WRITE_DATA_CLOCK), .wdclk_n(WRITE_DATA_CLOCK_N), .dq_drive(dq_drive),
      .slot_kind(slot_kind), .phase(phase)
   );
   ddrtb_top uut (
      .CLK(CLK), .RST(RST), .CK(CK), .LOAD_STROBE_N(LOAD_STROBE_N), .RW_SELECT(RW_SELECT),
      .ADDR_INPUTS(ADDR_INPUTS), .WRITE_DATA_CLOCK(WRITE_DATA_CLOCK),
      .WRITE_DATA_CLOCK_N(WRITE_DATA_CLOCK_N), .DQ_I(DQ_I), .DQ_O(DQ_O), .DQ_OE_N(DQ_OE_N),
      .ODT_EN(ODT_EN), .RD_REQ(RD_REQ), .RD_ADDR(RD_ADDR), .RD_Q1(RD_Q1), .RD_Q2(RD_Q2),
      .WR_VALID(WR_VALID), .WR_READY(WR_READY), .WR_ADDR(WR_ADDR), .WR_D1(WR_D1),
      .WR_D2(WR_D2), .OVERFLOW(OVERFLOW), .BUS_STATE(BUS_STATE)
   );

   // ****************************************************************
   // Slot monitor: expected bus state from the command history
   // ****************************************************************
   // Sampled mid-slot, so one cycle of synchroniser uncertainty cannot matter.
   always @(negedge CLK)
   begin
      if (RD_REQ)
      begin
         n_rd = n_rd + 1;
         last_rd = RD_ADDR;
      end
      if (mon_on && phase == 3'h0 && prev_st == `DDRTB_ST_READ)
         `CHECK(DQ_O, RD_Q2, "second read piece")
      if (phase == 3'h4)
      begin
         exp_st = (h2 == 2'h2) ? `DDRTB_ST_READ : (!h1[0] ? `DDRTB_ST_LOW : `DDRTB_ST_TERM);
         if (mon_on)
         begin
            `CHECK(BUS_STATE, exp_st, "bus slot state")
            `CHECK(DQ_OE_N, exp_st == `DDRTB_ST_TERM, "drive enable")
            `CHECK(ODT_EN, exp_st == `DDRTB_ST_TERM, "termination")
            if (exp_st != `DDRTB_ST_TERM)
               `CHECK(DQ_O, (exp_st == `DDRTB_ST_READ) ? RD_Q1 : {DW{1'b0}}, "low or first piece")
            if (u_ctrl.term_on)
               `CHECK(DQ_OE_N, 1'b0, "controller terminates an undriven bus")
         end
         prev_st = exp_st;
         h2 = h1;
         h1 = h0;
         h0 = slot_kind;
      end
   end

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   // Queues commands: r and w are idles of each side, R a read, W a numbered write.
   task push_seq(input string s);
      reg [DW-1:0] x;
      reg [1:0]    k;
      for (int j = 0; j < s.len(); j++)
      begin
         seq_n = seq_n + 1;
         x = {4{seq_n[8:0]}} ^ 36'hF0F0F0F0F;
         k = (s[j] == "W") ? 2'h3 : (s[j] == "R") ? 2'h2 : (s[j] == "w") ? 2'h1 : 2'h0;
         u_ctrl.push(k, seq_n[AW-1:0], x, ~x);
         if (k == 2'h3)
         begin
            e_addr.push_back(seq_n[AW-1:0]);
            e_d1.push_back(x);
            e_d2.push_back(~x);
         end
      end
   endtask

   // Waits for the queue to run dry, then past the read latency of the last command.
   task settle;
      int t;
      t = 0;
      while (u_ctrl.q_kind.size() != 0 && t < 4000)
      begin
         @(negedge CLK);
         t = t + 1;
      end
      `CHECK(t < 4000, 1'b1, "command queue stuck")
      repeat (48) @(negedge CLK);
   endtask

   // Takes every expected write word in order, one acknowledge at a time.
   task drain;
      int t;
      while (e_addr.size() > 0)
      begin
         t = 0;
         while (WR_VALID !== 1'b1 && t < 100)
         begin
            @(negedge CLK);
            t = t + 1;
         end
         `CHECK(WR_VALID, 1'b1, "write word missing")
         `CHECK(WR_ADDR, e_addr.pop_front(), "write address")
         `CHECK(WR_D1, e_d1.pop_front(), "first write piece")
         `CHECK(WR_D2, e_d2.pop_front(), "second write piece")
         WR_READY = 1'b1;
         @(negedge CLK);
         WR_READY = 1'b0;
         repeat (2) @(negedge CLK);
      end
      `CHECK(WR_VALID, 1'b0, "stray write word")
   endtask

   task wrap_up;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task t_reset;
      `CHECK(DQ_OE_N, 1'b0, "drive enable after reset")
      `CHECK(ODT_EN, 1'b0, "termination after reset")
      `CHECK(BUS_STATE, `DDRTB_ST_LOW, "state after reset")
      `CHECK(OVERFLOW, 1'b0, "overflow after reset")
      $display("test reset done");
   endtask

   // Write straight into a read, with no idles on either side.
   task t_wr_to_rd;
      push_seq("wwwWRrr");
      settle;
      `CHECK(n_rd, 1, "read request count")
      `CHECK(last_rd, AW'(seq_n - 2), "read address")
      drain;
      $display("test write to read done");
   endtask

   // Back-to-back reads, then the minimum idles into a write.
   task t_rd_to_wr;
      push_seq("RRrrwwwWr");
      settle;
      `CHECK(n_rd, 3, "read request count")
      drain;
      $display("test read to write done");
   endtask

   // Typical idle gaps around both turnarounds.
   task t_typical;
      push_seq("rrRrrrwwwwWrRrr");
      settle;
      `CHECK(last_rd, AW'(seq_n - 2), "read address")
      drain;
      $display("test typical gaps done");
   endtask

   // Nine words fill the buffer and output stage; the tenth is dropped.
   task t_overflow;
      push_seq("wwwWWWWWWWWW");
      settle;
      `CHECK(OVERFLOW, 1'b0, "overflow while room left")
      push_seq("wwwW");
      settle;
      `CHECK(OVERFLOW, 1'b1, "overflow on full buffer")
      void'(e_addr.pop_back());
      void'(e_d1.pop_back());
      void'(e_d2.pop_back());
      drain;
      $display("test overflow done");
   endtask

   // Main sequence.
   initial
   begin
      repeat (4) @(negedge CLK);
      RST = 1'b0;
      repeat (24) @(negedge CLK);
      t_reset;
      mon_on = 1'b1;
      t_wr_to_rd;
      t_rd_to_wr;
      t_typical;
      t_overflow;
      wrap_up;
   end

   // Watchdog, roughly eighteen times the expected run length.
   initial
   begin
      #100000;
      n_mismatch = n_mismatch + 1;
      wrap_up;
   end
endmodule // test_ddrtb_top
